// ==== core/dpc_pkg.sv ====
// Package of register map, field layout and timing for the PLL calibration register bank
package dpc_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CODE_W = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] VCO_LOGIC_CONTROL_OFS        = 12'h1b6;
    localparam logic [ADDR_W-1:0] SYNTH_RECAL_PUMP_OFFSET_OFS  = 12'h1b7;
    localparam logic [ADDR_W-1:0] PUMP_CALIBRATION_STATUS_OFS  = 12'h1b8;
    localparam logic [ADDR_W-1:0] PUMP_CALIBRATION_CONTROL_OFS = 12'h1b9;
    localparam logic [ADDR_W-1:0] PUMP_FORCED_CODE_OFS         = 12'h1ba;

    // Field positions
    localparam int unsigned LOGIC_RESET_BIT   = 6;
    localparam int unsigned BIT_SELECT_LSB    = 4;
    localparam int unsigned AMPLITUDE_LSB     = 0;
    localparam int unsigned SYNTH_RECAL_BIT   = 7;
    localparam int unsigned OFFSET_CUR_LSB    = 0;
    localparam int unsigned COMPARATOR_BIT    = 6;
    localparam int unsigned CAL_COMPLETE_BIT  = 5;
    localparam int unsigned OSC_CAL_BIT       = 4;
    localparam int unsigned CAL_RESULT_LSB    = 0;
    localparam int unsigned SLOW_CLOCK_BIT    = 7;
    localparam int unsigned DITHER_BIT        = 6;
    localparam int unsigned MACHINE_EN_BIT    = 5;
    localparam int unsigned OFFSET_OFF_BIT    = 4;
    localparam int unsigned OVERRIDE_BIT      = 3;
    localparam int unsigned CAL_ENABLE_BIT    = 2;
    localparam int unsigned TEST_SELECT_LSB   = 0;
    localparam int unsigned FORCED_CODE_LSB   = 0;

    // Reset values
    localparam logic       LOGIC_RESET_RST  = 1'h1;
    localparam logic [1:0] BIT_SELECT_RST   = 2'h0;
    localparam logic [3:0] AMPLITUDE_RST    = 4'ha;
    localparam logic       SYNTH_RECAL_RST  = 1'h0;
    localparam logic [5:0] OFFSET_CUR_RST   = 6'h00;
    localparam logic       SLOW_CLOCK_RST   = 1'h0;
    localparam logic       DITHER_RST       = 1'h0;
    localparam logic       MACHINE_EN_RST   = 1'h1;
    localparam logic       OFFSET_OFF_RST   = 1'h1;
    localparam logic       OVERRIDE_RST     = 1'h0;
    localparam logic       CAL_ENABLE_RST   = 1'h1;
    localparam logic [1:0] TEST_SELECT_RST  = 2'h0;
    localparam logic [3:0] FORCED_CODE_RST  = 4'h0;

    // Calibration clock timing
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned CAL_TICK_NS      = 200;
    localparam int unsigned CAL_TICK_CYCLES  = (CAL_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIV_W            = 4;
    localparam logic [DIV_W-1:0] TICK_NORMAL = DIV_W'(CAL_TICK_CYCLES - 1);
    localparam logic [DIV_W-1:0] TICK_SLOW   = DIV_W'(2 * CAL_TICK_CYCLES - 1);
    localparam int unsigned OSC_CAL_TICKS    = 8;
    localparam int unsigned STEP_W           = 4;
    localparam logic [STEP_W-1:0] OSC_LAST   = STEP_W'(OSC_CAL_TICKS - 1);
    localparam logic [CODE_W-1:0] SAR_START  = 4'h8;

    typedef enum logic [2:0] {
        DPC_IDLE,
        DPC_OSC_CAL,
        DPC_PUMP_CAL,
        DPC_DONE
    } dpc_state_e;

    // Register access port
    typedef struct packed {
        logic              wr_en;
        logic              rd_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dpc_req_s;

    // Controls driven into the analog PLL
    typedef struct packed {
        logic              oscillator_logic_reset_n;
        logic [1:0]        oscillator_bit_select;
        logic [3:0]        oscillator_amplitude;
        logic              manual_synth_recal;
        logic [5:0]        pump_offset_current;
        logic              pump_offset_disable;
        logic              dither_mode;
        logic [1:0]        pump_test_select;
        logic              oscillator_cal_clock;
        logic [CODE_W-1:0] pump_cal_code;
    } dpc_ctrl_s;

endpackage

// ==== core/dpc_regs.sv ====
// PLL calibration and test register bank with its power-up calibration sequencer
`timescale 1ns/100ps

// Summary of operation
// - Bit 6 of the oscillator control register is a read/write logic reset control that resets to 1 (released).
// - Bit 7 of the recalibration register is read/write, resets to 0, and drives the manual synthesizer recalibration control.
// - Status bit 6 shows the live charge-pump calibration comparator output and reads 0 after reset.
// - Status bit 5 flags completed pump calibration, bit 4 shows oscillator calibration and [3:0] the code.
// - Control bit 7, reset 0, halves the oscillator calibration clock rate when set.
// - Control bit 5, reset 1, enables the power-mode sequencing machine, which does not run when cleared.
// - Control bit 3, reset 0, selects the externally supplied pump calibration code over the calibrated one.
// - Control bit 2, reset 1, enables pump calibration, which is skipped when cleared.
// - The forced pump code comes from its own 4-bit field and applies only while the machine is off.
// - While enabled the machine calibrates the pump and keeps the result for readback.
module dpc_regs (
    input  wire logic                            core_clk,
    input  wire logic                            resetn,
    input  wire dpc_pkg::dpc_req_s               reg_req,
    output logic [dpc_pkg::DATA_W-1:0]           reg_rdata,
    input  wire logic                            pump_comparator,
    output dpc_pkg::dpc_ctrl_s                   pll_ctrl
);

    typedef struct packed {
        logic                            logic_reset_n;
        logic [1:0]                      bit_select;
        logic [3:0]                      amplitude;
        logic                            synth_recal;
        logic [5:0]                      offset_cur;
        logic                            slow_clock;
        logic                            dither;
        logic                            machine_en;
        logic                            offset_off;
        logic                            override;
        logic                            cal_enable;
        logic [1:0]                      test_select;
        logic [dpc_pkg::CODE_W-1:0]      forced_code;
        logic                            comparator;
        logic                            complete;
        logic [dpc_pkg::CODE_W-1:0]      result;
        logic [dpc_pkg::CODE_W-1:0]      trial;
        logic [1:0]                      bit_idx;
        logic [dpc_pkg::STEP_W-1:0]      steps;
        logic [dpc_pkg::DIV_W-1:0]       div;
        logic                            cal_clock;
        logic                            machine_en_d;
        dpc_pkg::dpc_state_e             state;
        logic [dpc_pkg::DATA_W-1:0]      rdata;
    } dpc_state_s;

    dpc_state_s st_reg;
    dpc_state_s st_next;

    logic                        tick;
    logic [dpc_pkg::DATA_W-1:0]  rd_value;
    logic                        wr;

    assign wr   = reg_req.wr_en;
    // Calibration tick pacing; slow mode doubles the divider
    assign tick = (st_reg.div == (st_reg.slow_clock ? dpc_pkg::TICK_SLOW : dpc_pkg::TICK_NORMAL));

    always_comb begin
        rd_value = '0;
        if (reg_req.addr == dpc_pkg::VCO_LOGIC_CONTROL_OFS) begin
            rd_value[dpc_pkg::LOGIC_RESET_BIT]                   = st_reg.logic_reset_n;
            rd_value[dpc_pkg::BIT_SELECT_LSB +: 2]               = st_reg.bit_select;
            rd_value[dpc_pkg::AMPLITUDE_LSB +: 4]                = st_reg.amplitude;
        end else if (reg_req.addr == dpc_pkg::SYNTH_RECAL_PUMP_OFFSET_OFS) begin
            rd_value[dpc_pkg::SYNTH_RECAL_BIT]                   = st_reg.synth_recal;
            rd_value[dpc_pkg::OFFSET_CUR_LSB +: 6]               = st_reg.offset_cur;
        end else if (reg_req.addr == dpc_pkg::PUMP_CALIBRATION_STATUS_OFS) begin
            rd_value[dpc_pkg::COMPARATOR_BIT]                    = st_reg.comparator;
            rd_value[dpc_pkg::CAL_COMPLETE_BIT]                  = st_reg.complete;
            rd_value[dpc_pkg::OSC_CAL_BIT]                       = (st_reg.state == dpc_pkg::DPC_OSC_CAL);
            rd_value[dpc_pkg::CAL_RESULT_LSB +: dpc_pkg::CODE_W] = st_reg.result;
        end else if (reg_req.addr == dpc_pkg::PUMP_CALIBRATION_CONTROL_OFS) begin
            rd_value[dpc_pkg::SLOW_CLOCK_BIT]                    = st_reg.slow_clock;
            rd_value[dpc_pkg::DITHER_BIT]                        = st_reg.dither;
            rd_value[dpc_pkg::MACHINE_EN_BIT]                    = st_reg.machine_en;
            rd_value[dpc_pkg::OFFSET_OFF_BIT]                    = st_reg.offset_off;
            rd_value[dpc_pkg::OVERRIDE_BIT]                      = st_reg.override;
            rd_value[dpc_pkg::CAL_ENABLE_BIT]                    = st_reg.cal_enable;
            rd_value[dpc_pkg::TEST_SELECT_LSB +: 2]              = st_reg.test_select;
        end else if (reg_req.addr == dpc_pkg::PUMP_FORCED_CODE_OFS) begin
            rd_value[dpc_pkg::FORCED_CODE_LSB +: dpc_pkg::CODE_W] = st_reg.forced_code;
        end
    end

    always_comb begin
        st_next            = st_reg;
        st_next.comparator = pump_comparator;
        st_next.machine_en_d = st_reg.machine_en;
        st_next.div        = tick ? '0 : st_reg.div + 1'b1;
        if (tick) begin
            st_next.cal_clock = ~st_reg.cal_clock;
        end
        if (reg_req.rd_en) begin
            st_next.rdata = rd_value;
        end

        // Status register and reserved bits have no write path
        if (wr && reg_req.addr == dpc_pkg::VCO_LOGIC_CONTROL_OFS) begin
            st_next.logic_reset_n = reg_req.wdata[dpc_pkg::LOGIC_RESET_BIT];
            st_next.bit_select    = reg_req.wdata[dpc_pkg::BIT_SELECT_LSB +: 2];
            st_next.amplitude     = reg_req.wdata[dpc_pkg::AMPLITUDE_LSB +: 4];
        end else if (wr && reg_req.addr == dpc_pkg::SYNTH_RECAL_PUMP_OFFSET_OFS) begin
            st_next.synth_recal   = reg_req.wdata[dpc_pkg::SYNTH_RECAL_BIT];
            st_next.offset_cur    = reg_req.wdata[dpc_pkg::OFFSET_CUR_LSB +: 6];
        end else if (wr && reg_req.addr == dpc_pkg::PUMP_CALIBRATION_CONTROL_OFS) begin
            st_next.slow_clock    = reg_req.wdata[dpc_pkg::SLOW_CLOCK_BIT];
            st_next.dither        = reg_req.wdata[dpc_pkg::DITHER_BIT];
            st_next.machine_en    = reg_req.wdata[dpc_pkg::MACHINE_EN_BIT];
            st_next.offset_off    = reg_req.wdata[dpc_pkg::OFFSET_OFF_BIT];
            st_next.override      = reg_req.wdata[dpc_pkg::OVERRIDE_BIT];
            st_next.cal_enable    = reg_req.wdata[dpc_pkg::CAL_ENABLE_BIT];
            st_next.test_select   = reg_req.wdata[dpc_pkg::TEST_SELECT_LSB +: 2];
        end else if (wr && reg_req.addr == dpc_pkg::PUMP_FORCED_CODE_OFS) begin
            st_next.forced_code   = reg_req.wdata[dpc_pkg::FORCED_CODE_LSB +: dpc_pkg::CODE_W];
        end

        // Power-up sequencer: oscillator calibration, then a binary search on the pump code
        case (st_reg.state)
            dpc_pkg::DPC_IDLE: begin
                if (st_reg.machine_en && !st_reg.machine_en_d) begin
                    st_next.state    = dpc_pkg::DPC_OSC_CAL;
                    st_next.steps    = '0;
                    st_next.complete = 1'b0;
                end
            end
            dpc_pkg::DPC_OSC_CAL: begin
                if (tick) begin
                    st_next.steps = st_reg.steps + 1'b1;
                    if (st_reg.steps == dpc_pkg::OSC_LAST) begin
                        if (st_reg.cal_enable) begin
                            st_next.state   = dpc_pkg::DPC_PUMP_CAL;
                            st_next.trial   = dpc_pkg::SAR_START;
                            st_next.bit_idx = 2'h3;
                        end else begin
                            st_next.state   = dpc_pkg::DPC_DONE;
                        end
                    end
                end
            end
            dpc_pkg::DPC_PUMP_CAL: begin
                if (tick) begin
                    // Comparator high keeps the trial bit; low drops it
                    st_next.trial[st_reg.bit_idx] = st_reg.comparator;
                    if (st_reg.bit_idx == 2'h0) begin
                        st_next.result   = {st_reg.trial[3:1], st_reg.comparator};
                        st_next.complete = 1'b1;
                        st_next.state    = dpc_pkg::DPC_DONE;
                    end else begin
                        st_next.trial[st_reg.bit_idx - 2'h1] = 1'b1;
                        st_next.bit_idx = st_reg.bit_idx - 2'h1;
                    end
                end
            end
            dpc_pkg::DPC_DONE: begin
                // Result stays held until a later pump calibration completes
                st_next.state = dpc_pkg::DPC_DONE;
            end
            default: begin
                st_next.state = dpc_pkg::DPC_IDLE;
            end
        endcase
        if (!st_reg.machine_en) begin
            st_next.state = dpc_pkg::DPC_IDLE;
        end

        if (!resetn) begin
            st_next               = '0;
            st_next.logic_reset_n = dpc_pkg::LOGIC_RESET_RST;
            st_next.bit_select    = dpc_pkg::BIT_SELECT_RST;
            st_next.amplitude     = dpc_pkg::AMPLITUDE_RST;
            st_next.synth_recal   = dpc_pkg::SYNTH_RECAL_RST;
            st_next.offset_cur    = dpc_pkg::OFFSET_CUR_RST;
            st_next.slow_clock    = dpc_pkg::SLOW_CLOCK_RST;
            st_next.dither        = dpc_pkg::DITHER_RST;
            st_next.machine_en    = dpc_pkg::MACHINE_EN_RST;
            st_next.offset_off    = dpc_pkg::OFFSET_OFF_RST;
            st_next.override      = dpc_pkg::OVERRIDE_RST;
            st_next.cal_enable    = dpc_pkg::CAL_ENABLE_RST;
            st_next.test_select   = dpc_pkg::TEST_SELECT_RST;
            st_next.forced_code   = dpc_pkg::FORCED_CODE_RST;
            // Leaving machine_en_d low starts a calibration after reset release
            st_next.state         = dpc_pkg::DPC_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        st_reg <= st_next;
    end

    assign reg_rdata = st_reg.rdata;

    always_comb begin
        pll_ctrl.oscillator_logic_reset_n = st_reg.logic_reset_n;
        pll_ctrl.oscillator_bit_select    = st_reg.bit_select;
        pll_ctrl.oscillator_amplitude     = st_reg.amplitude;
        pll_ctrl.manual_synth_recal       = st_reg.synth_recal;
        pll_ctrl.pump_offset_current      = st_reg.offset_cur;
        pll_ctrl.pump_offset_disable      = st_reg.offset_off;
        pll_ctrl.dither_mode              = st_reg.dither;
        pll_ctrl.pump_test_select         = st_reg.test_select;
        pll_ctrl.oscillator_cal_clock     = st_reg.cal_clock;
        // During the search the trial code drives the pump so the comparator sees it
        if (st_reg.override && !st_reg.machine_en) begin
            pll_ctrl.pump_cal_code = st_reg.forced_code;
        end else if (st_reg.state == dpc_pkg::DPC_PUMP_CAL) begin
            pll_ctrl.pump_cal_code = st_reg.trial;
        end else begin
            pll_ctrl.pump_cal_code = st_reg.result;
        end
    end

endmodule

// ==== sim/dpc_regs_props.sv ====
// Port-level assertions for the PLL calibration register bank
`timescale 1ns/100ps
module dpc_regs_props (
    input wire logic               core_clk,
    input wire logic               resetn,
    input wire dpc_pkg::dpc_req_s  reg_req,
    input wire logic [7:0]         reg_rdata,
    input wire logic               pump_comparator,
    input wire dpc_pkg::dpc_ctrl_s pll_ctrl
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_unmapped_zero: assert property (reg_req.rd_en && !(reg_req.addr inside {[12'h1b6:12'h1ba]})
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_status_resv: assert property (reg_req.rd_en && reg_req.addr == 12'h1b8
        |=> !reg_rdata[7]) else $error("status reserved bit set");
    a_osc_resv: assert property (reg_req.rd_en && reg_req.addr == 12'h1b6
        |=> !reg_rdata[7]) else $error("oscillator reserved bit set");
    a_recal_resv: assert property (reg_req.rd_en && reg_req.addr == 12'h1b7
        |=> !reg_rdata[6]) else $error("recal reserved bit set");
    a_forced_resv: assert property (reg_req.rd_en && reg_req.addr == 12'h1ba
        |=> reg_rdata[7:4] == 4'h0) else $error("forced code upper nibble set");
    a_osc_write: assert property (reg_req.wr_en && reg_req.addr == 12'h1b6
        |=> {pll_ctrl.oscillator_logic_reset_n, pll_ctrl.oscillator_bit_select, pll_ctrl.oscillator_amplitude}
            == $past(reg_req.wdata[6:0])) else $error("oscillator controls not written");
    a_recal_write: assert property (reg_req.wr_en && reg_req.addr == 12'h1b7
        |=> {pll_ctrl.manual_synth_recal, pll_ctrl.pump_offset_current}
            == {$past(reg_req.wdata[7]), $past(reg_req.wdata[5:0])}) else $error("recal controls not written");
    // Comparator held still so either sync latency gives the same bit
    a_comparator_echo: assert property ($stable(pump_comparator)[*3] ##0 reg_req.rd_en && reg_req.addr == 12'h1b8
        |=> reg_rdata[6] == $past(pump_comparator)) else $error("comparator bit wrong");
    a_cal_tick_gap: assert property ($changed(pll_ctrl.oscillator_cal_clock)
        |=> !$changed(pll_ctrl.oscillator_cal_clock)[*3]) else $error("calibration clock ticks too fast");
    a_reset_values: assert property (disable iff (1'b0) !resetn |=> reg_rdata == 8'h00
        && pll_ctrl.oscillator_logic_reset_n && pll_ctrl.oscillator_amplitude == 4'ha && !pll_ctrl.manual_synth_recal
        && !pll_ctrl.oscillator_cal_clock) else $error("reset values wrong");
endmodule
bind dpc_regs dpc_regs_props u_props (.core_clk(core_clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .pump_comparator(pump_comparator), .pll_ctrl(pll_ctrl));

// ==== sim/dpc_regs_bench.sv ====
// Self-checking bench for the PLL calibration register bank
`timescale 1ns/100ps
module dpc_regs_bench;
    logic               core_clk = 1'b0;
    logic               resetn = 1'b0;
    dpc_pkg::dpc_req_s  req = '0;
    logic               comp = 1'b0;
    logic [7:0]         rdata;
    dpc_pkg::dpc_ctrl_s ctrl;
    int                 n_mismatch = 0;
    int                 tests_run = 0;
    logic [31:0]        seed = 32'h0000005d;
    logic [11:0]        addr_tab [4] = '{12'h1b6, 12'h1b7, 12'h1b9, 12'h1ba};
    logic [7:0]         mask_tab [4] = '{8'h7f, 8'hbf, 8'hff, 8'h0f};
    logic [7:0]         rst_tab [4] = '{8'h4a, 8'h00, 8'h34, 8'h00};

    always #25 core_clk = ~core_clk;

    dpc_regs DUT (.core_clk(core_clk), .resetn(resetn), .reg_req(req), .reg_rdata(rdata),
        .pump_comparator(comp), .pll_ctrl(ctrl));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic wrap_up;
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req.wr_en <= 1'b1; req.addr <= a; req.wdata <= d;
        @(posedge core_clk);
        req.wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req.rd_en <= 1'b1; req.addr <= a;
        @(posedge core_clk);
        req.rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    // Sequencer restart needs machine enable low then high
    task automatic run_cal(input logic c, input logic en);
        logic [7:0] d;
        int k;
        comp <= c;
        wr(12'h1b9, 8'h14);
        wr(12'h1b9, en ? 8'h34 : 8'h30);
        d = 8'h00; k = 0;
        while (d[4] !== 1'b1 && k < 30) begin rd(12'h1b8, d); k++; end
        chk("osc_cal_active", 8'h01, {7'h0, d[4]});
        k = 0;
        while (d[5] !== 1'b1 && k < 60) begin rd(12'h1b8, d); k++; end
        if (en) begin
            chk("pump_status", {1'b0, c, 2'b10, {4{c}}}, d);
            chk("pump_cal_code", {4'h0, {4{c}}}, {4'h0, ctrl.pump_cal_code});
        end else chk("pump_status_skip", {1'b0, c, 6'h00}, {d[7:4], 4'h0});
    endtask

    task automatic toggle_wait(output int k);
        logic c;
        #1 c = ctrl.oscillator_cal_clock;
        k = 0;
        while (ctrl.oscillator_cal_clock === c && k < 20) begin @(posedge core_clk); #1 k++; end
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        logic [7:0] d, g;
        int idx, n;
        repeat (6) @(posedge core_clk);
        #1 chk("rdata_in_reset", 8'h00, rdata);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(addr_tab[i], g);
            chk("reset_value", rst_tab[i], g);
        end
        // All-ones and all-zeros corners first, then random bytes
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            idx = (i < 8) ? i % 4 : int'(seed[1:0]);
            d = (i < 4) ? 8'hff : (i < 8) ? 8'h00 : seed[15:8];
            wr(addr_tab[idx], d);
            rd(addr_tab[idx], g);
            chk("readback", d & mask_tab[idx], g);
            if (idx == 0) chk("osc_ctrl", {1'b0, d[6:0]}, {1'b0, ctrl.oscillator_logic_reset_n,
                ctrl.oscillator_bit_select, ctrl.oscillator_amplitude});
            if (idx == 2) chk("cal_ctrl", {4'h0, d[6], d[4], d[1:0]}, {4'h0, ctrl.dither_mode,
                ctrl.pump_offset_disable, ctrl.pump_test_select});
        end
        wr(12'h1b8, 8'hff);
        wr(12'h1bb, 8'hff);
        rd(12'h1bb, g);
        chk("unmapped", 8'h00, g);
        rd(12'h1b8, g);
        chk("status_resv", 8'h00, g & 8'h80);
        run_cal(1'b0, 1'b1);
        run_cal(1'b1, 1'b0);
        run_cal(1'b1, 1'b1);
        seed = xs(seed);
        wr(12'h1b9, 8'h18);
        wr(12'h1ba, seed[7:0] & 8'h07);
        rd(12'h1b8, g);
        chk("machine_off", 8'h00, g & 8'h10);
        chk("forced_code", seed[7:0] & 8'h07, {4'h0, ctrl.pump_cal_code});
        wr(12'h1b9, 8'h10);
        // Let the write edge settle before looking at the mux output
        #1 chk("kept_code", 8'h0f, {4'h0, ctrl.pump_cal_code});
        wr(12'h1b9, 8'h34);
        toggle_wait(n);
        toggle_wait(n);
        chk("cal_tick", 8'(dpc_pkg::CAL_TICK_CYCLES), 8'(n));
        wr(12'h1b9, 8'hb4);
        toggle_wait(n);
        toggle_wait(n);
        toggle_wait(n);
        chk("cal_tick_slow", 8'(2 * dpc_pkg::CAL_TICK_CYCLES), 8'(n));
        wrap_up();
    end
endmodule
